// file: vertical_sync_extractor.sv
// Composite sync stripper and vertical sync pulse generator, clocked form.
// Assumes digitized video sampled on clk_i and thresholds held static.
module vertical_sync_extractor (
    input  wire logic                          clk_i,         // 25 MHz clock
    input  wire logic                          reset_n_i,     // Sync reset
    input  wire logic [vsync_pkg::VIDEO_W-1:0] video_i,       // Video sample
    input  wire logic [vsync_pkg::VIDEO_W-1:0] black_level_i, // Sync slice
    input  wire logic [vsync_pkg::INTEG_W-1:0] charge_step_i, // Up rate
    input  wire logic [vsync_pkg::INTEG_W-1:0] discharge_step_i, // Down rate
    input  wire logic [vsync_pkg::INTEG_W-1:0] vertical_detect_threshold_i,
    input  wire logic [vsync_pkg::INTEG_W-1:0] default_trigger_threshold_i,
    input  wire logic [vsync_pkg::PER_W-1:0]   osc_period_i,  // Osc clocks
    output logic                               composite_sync_n_o, // Sync, low
    output logic                               vertical_sync_o,    // Pulse
    output logic                               field_clock_o       // 1 cycle
);
    typedef struct packed {
        logic                          sync_pos;
        logic                          sync_prev;
        logic                          csync_n;
        logic [vsync_pkg::INTEG_W-1:0] integ;
        logic                          latch;
        logic                          dflt_prev;
        logic                          vsync;
        logic                          field_clk;
        logic [vsync_pkg::PER_W-1:0]   per;
    } vs_state_t;

    vs_state_t s_q;
    vs_state_t s_d;
    osc_if     osc_link ();

    logic                          below;
    logic                          serration_edge;
    logic                          detect_hit;
    logic                          dflt_hit;
    logic                          set_req;
    logic [vsync_pkg::INTEG_W:0]   up_sum;

    vsync_osc u_osc (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .link      (osc_link)
    );

    assign osc_link.enable = s_q.vsync;
    assign osc_link.period = s_q.per;

    always_comb begin
        below          = video_i < black_level_i;
        serration_edge = s_q.sync_prev && !s_q.sync_pos;
        detect_hit     = s_q.integ >= vertical_detect_threshold_i;
        dflt_hit       = s_q.integ >= default_trigger_threshold_i;
        set_req        = (serration_edge && detect_hit)
                         || (dflt_hit && !s_q.dflt_prev);
        up_sum         = {1'b0, s_q.integ} + {1'b0, charge_step_i};
        s_d            = s_q;
        s_d.sync_pos   = below;
        s_d.sync_prev  = s_q.sync_pos;
        s_d.csync_n    = !below;
        s_d.dflt_prev  = dflt_hit;
        // Integrator charges in sync, bleeds between syncs
        if (s_q.sync_pos) begin
            s_d.integ = up_sum[vsync_pkg::INTEG_W] ? vsync_pkg::INTEG_MAX
                      : up_sum[vsync_pkg::INTEG_W-1:0];
        end else if (s_q.integ > discharge_step_i) begin
            s_d.integ = s_q.integ - discharge_step_i;
        end else begin
            s_d.integ = vsync_pkg::INTEG_RST;
        end
        if (serration_edge) begin
            s_d.latch = detect_hit;
        end
        s_d.field_clk = 1'b0;
        if (osc_link.done) begin
            s_d.vsync = 1'b0;
        end else if (set_req && !s_q.vsync) begin
            s_d.vsync     = 1'b1;
            s_d.field_clk = 1'b1;
            s_d.per       = osc_period_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s_q         <= '0;
            s_q.csync_n <= 1'b1;
            s_q.per     <= vsync_pkg::PER_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign composite_sync_n_o = s_q.csync_n;
    assign vertical_sync_o    = s_q.vsync;
    assign field_clock_o      = s_q.field_clk;

    // Helper: length of the current vertical pulse
    logic [31:0] len_q;
    logic [31:0] per_eff32;
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || !s_q.vsync) begin
            len_q <= 32'h0000_0001;
        end else begin
            len_q <= len_q + 32'h0000_0001;
        end
    end
    assign per_eff32 = (s_q.per < vsync_pkg::PER_MIN) ? 32'h0000_0001
                                                       : 32'(s_q.per);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    property p_csync;
        ##1 composite_sync_n_o == !$past(video_i < black_level_i);
    endproperty
    a_csync: assert property (p_csync) else $error("csync mismatch");

    property p_integ_up;
        s_q.sync_pos |=> s_q.integ >= $past(s_q.integ);
    endproperty
    a_integ_up: assert property (p_integ_up)
        else $error("integrator fell in sync");

    property p_integ_down;
        !s_q.sync_pos && s_q.integ != '0 |=> s_q.integ < $past(s_q.integ)
            || discharge_step_i == '0;
    endproperty
    a_integ_down: assert property (p_integ_down)
        else $error("integrator rose out of sync");

    property p_serr_set;
        serration_edge && detect_hit && !s_q.vsync |=> vertical_sync_o;
    endproperty
    a_serr_set: assert property (p_serr_set)
        else $error("serration did not start pulse");

    property p_dflt_set;
        dflt_hit && !s_q.dflt_prev && !s_q.vsync |=> vertical_sync_o;
    endproperty
    a_dflt_set: assert property (p_dflt_set)
        else $error("default did not start pulse");

    property p_no_spurious;
        !vertical_sync_o && !set_req |=> !vertical_sync_o;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("pulse without trigger");

    property p_field_clk;
        $rose(vertical_sync_o) |-> field_clock_o;
    endproperty
    a_field_clk: assert property (p_field_clk)
        else $error("field clock missing");

    property p_field_one;
        field_clock_o |=> !field_clock_o;
    endproperty
    a_field_one: assert property (p_field_one)
        else $error("field clock too long");

    property p_width;
        vertical_sync_o ##1 !vertical_sync_o
            |-> $past(len_q) == 32'(vsync_pkg::OSC_CYCLES) * per_eff32;
    endproperty
    a_width: assert property (p_width)
        else $error("pulse width not eight periods");

    property p_latch;
        serration_edge |=> s_q.latch == $past(detect_hit);
    endproperty
    a_latch: assert property (p_latch) else $error("latch missed");

    property p_hold;
        vertical_sync_o && !osc_link.done |=> vertical_sync_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("pulse ended early");

    property p_per_hold;
        vertical_sync_o |=> !vertical_sync_o || $stable(s_q.per);
    endproperty
    a_per_hold: assert property (p_per_hold)
        else $error("period moved in pulse");

    property p_done_in_pulse;
        osc_link.done |-> vertical_sync_o;
    endproperty
    a_done_in_pulse: assert property (p_done_in_pulse)
        else $error("divider ended outside pulse");

    property p_field_in_pulse;
        field_clock_o |-> vertical_sync_o;
    endproperty
    a_field_in_pulse: assert property (p_field_in_pulse)
        else $error("field clock outside pulse");

    // Reset check must run while reset is low
    property p_reset_out;
        @(posedge clk_i) disable iff (1'b0)
        !reset_n_i |=> composite_sync_n_o && !vertical_sync_o
            && !field_clock_o;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not cleared by reset");

    c_serr: cover property (serration_edge && detect_hit && !s_q.vsync);
    c_dflt: cover property (dflt_hit && !s_q.dflt_prev && !s_q.vsync);
    c_end:  cover property (vertical_sync_o ##1 !vertical_sync_o);
    c_refused: cover property (vertical_sync_o && set_req);
endmodule : vertical_sync_extractor

// file: vsync_pkg.sv
// Shared widths, reset values and counts for the vertical sync extractor.
// Assumes one 25 MHz clock and a synchronous active-low reset.
package vsync_pkg;
    localparam int unsigned        VIDEO_W    = 8;
    localparam int unsigned        INTEG_W    = 16;
    localparam int unsigned        PER_W      = 16;
    localparam int unsigned        DIV_W      = 3;
    localparam logic [DIV_W-1:0]   DIV_LAST   = 3'h7;
    localparam int unsigned        OSC_CYCLES = 8;
    localparam logic [INTEG_W-1:0] INTEG_RST  = 16'h0000;
    localparam logic [INTEG_W-1:0] INTEG_MAX  = 16'hFFFF;
    localparam logic [PER_W-1:0]   PER_RST    = 16'h0001;
    localparam logic [PER_W-1:0]   PER_MIN    = 16'h0001;
endpackage : vsync_pkg

// file: osc_if.sv
// Link between the pulse flip-flop and the oscillator/divider.
// Assumes both ends share clk_i.
interface osc_if;
    logic                          enable;  // Pulse flip-flop set
    logic [vsync_pkg::PER_W-1:0]   period;  // Clocks per oscillator cycle
    logic                          done;    // Eighth cycle ends now
    modport ctrl (output enable, output period, input done);
    modport osc  (input enable, input period, output done);
endinterface : osc_if

// file: vsync_osc.sv
// Gated oscillator tick divider followed by a divide-by-eight stage.
// Assumes period is held stable while enable is high.
module vsync_osc (
    input  wire logic clk_i,     // 25 MHz system clock
    input  wire logic reset_n_i, // Synchronous reset, active low
    osc_if.osc        link       // Enable in, done out
);
    typedef struct packed {
        logic [vsync_pkg::PER_W-1:0] cnt;
        logic [vsync_pkg::DIV_W-1:0] div;
    } osc_state_t;

    osc_state_t s_q;
    osc_state_t s_d;
    logic [vsync_pkg::PER_W-1:0] per_eff;
    logic                        tick;

    always_comb begin
        per_eff = (link.period < vsync_pkg::PER_MIN) ? vsync_pkg::PER_MIN
                                                      : link.period;
        tick = link.enable
               && (s_q.cnt == per_eff - vsync_pkg::PER_MIN);
        link.done = tick && (s_q.div == vsync_pkg::DIV_LAST);
        s_d = s_q;
        if (!link.enable) begin
            s_d = '0;
        end else if (tick) begin
            s_d.cnt = '0;
            s_d.div = s_q.div + 3'h1;
        end else begin
            s_d.cnt = s_q.cnt + vsync_pkg::PER_MIN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : vsync_osc

// file: video_src.sv
// Behavioural composite video source for the sync extractor bench.
// Assumes black_i is above zero and start_i is a one-clock request.
module video_src (
    input  wire logic        clk_i,     // Bench clock
    input  wire logic        start_i,   // Begin a burst of segments
    input  wire logic [15:0] low_len_i, // Sync clocks per segment
    input  wire logic [15:0] hi_len_i,  // Picture clocks per segment
    input  wire logic [15:0] count_i,   // Segments in the burst
    input  wire logic [7:0]  black_i,   // Black level
    output logic      [7:0]  video_o,   // Video sample
    output logic             busy_o     // Burst in progress
);
    timeunit 1ns;
    timeprecision 1ns;
    logic go;
    initial begin
        video_o = 8'hFF;
        busy_o  = 1'b0;
        forever begin
            @(posedge clk_i);
            // Request taken on the edge, before the bench moves it
            go = (start_i === 1'b1);
            #1;
            if (go) begin
                busy_o = 1'b1;
                for (int n = 0; n < count_i; n++) begin
                    for (int k = 0; k < low_len_i; k++) begin
                        video_o = 8'($urandom_range(black_i - 1, 0));
                        @(posedge clk_i);
                        #1;
                    end
                    for (int k = 0; k < hi_len_i; k++) begin
                        video_o = 8'($urandom_range(8'hFF, black_i));
                        @(posedge clk_i);
                        #1;
                    end
                end
                busy_o = 1'b0;
            end
            // Picture level that changes every clock
            video_o = 8'($urandom_range(8'hFF, black_i));
        end
    end
endmodule : video_src

// file: tb_vertical_sync_extractor.sv
// Self-checking bench for the vertical sync extractor.
// Assumes the source model drives video; the bench drives all else.
module tb_vertical_sync_extractor;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [7:0]  video, black = 8'h40;
    logic [15:0] chg = 16'h0010, dis = 16'h0010;
    logic [15:0] det = 16'h0100, dft = 16'h0400, per = 16'h001E;
    logic [15:0] lo = 16'h0000, hi = 16'h0000, cnt = 16'h0000;
    logic        start = 1'b0, busy, cs_n, vs, fc, cs_exp = 1'b1;
    int          fail_count = 0, check_count = 0, width = 0, cycles = 0;
    int          exp_q[$];
    initial forever #20 clk_i = ~clk_i;
    video_src src (.clk_i(clk_i), .start_i(start), .low_len_i(lo),
        .hi_len_i(hi), .count_i(cnt), .black_i(black), .video_o(video),
        .busy_o(busy));
    vertical_sync_extractor dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .video_i(video), .black_level_i(black), .charge_step_i(chg),
        .discharge_step_i(dis), .vertical_detect_threshold_i(det),
        .default_trigger_threshold_i(dft), .osc_period_i(per),
        .composite_sync_n_o(cs_n), .vertical_sync_o(vs),
        .field_clock_o(fc));
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic run(input logic [15:0] l, h, c, input int idle);
        @(posedge clk_i);
        #1 {lo, hi, cnt, start} = {l, h, c, 1'b1};
        @(posedge clk_i);
        #1 start = 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_i);
        check("source_idle", busy, 1'b0);
        repeat (idle) @(posedge clk_i);
    endtask : run
    always @(posedge clk_i) begin
        cs_exp = (reset_n_i !== 1'b1) ? 1'b1 : !(video < black);
        cycles++;
        if (cycles > 6000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // Watcher: sync every clock, pulse width against the oldest note
    always @(negedge clk_i) begin
        check("composite_sync_n", cs_n, cs_exp);
        if (vs === 1'b1) begin
            check("field_clock", fc, width == 0);
            width++;
        end else if (width > 0) begin
            check("pulse_expected", exp_q.size() > 0, 1);
            if (exp_q.size() > 0)
                check("pulse_width", width, exp_q.pop_front());
            width = 0;
        end
    end
    initial begin
        void'($urandom(32'hf18c));
        repeat (5) @(posedge clk_i);
        #1 reset_n_i = 1'b1;
        run(16'h0004, 16'h001C, 16'h000A, 20);
        run(16'h0002, 16'h000E, 16'h000C, 20);
        exp_q.push_back(8 * 30);
        run(16'h001E, 16'h0004, 16'h0006, 300);
        #1 per = 16'h0000;
        exp_q.push_back(8);
        exp_q.push_back(8);
        run(16'h0064, 16'h0000, 16'h0001, 300);
        check("pulses_left", exp_q.size(), 0);
        report_and_stop();
    end
endmodule : tb_vertical_sync_extractor
